// *** tgm_pkg.sv ***
// constants and types for the test and general pin signal mux
package tgm_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [9:0] TGM_OFF_PROBE = 10'h3f8;
   localparam logic [9:0] TGM_OFF_RSSI  = 10'h3f9;
   localparam logic [9:0] TGM_OFF_PINFN = 10'h3fa;
   localparam logic [9:0] TGM_OFF_SCALE = 10'h3fd;

   localparam logic [7:0] TGM_RST_PROBE = 8'h00;
   localparam logic [7:0] TGM_RST_RSSI  = 8'h00;
   localparam logic [7:0] TGM_RST_PINFN = 8'h00;
   localparam logic [7:0] TGM_RST_SCALE = 8'h04;

   // field positions
   localparam int TGM_RSSI_SEL_LSB  = 0;
   localparam int TGM_RSSI_SEL_W    = 2;
   localparam int TGM_SCALE_LSB     = 0;
   localparam int TGM_SCALE_W       = 4;

   // ----------------------------------------------------------------
   // codes
   // ----------------------------------------------------------------
   localparam logic [7:0] TGM_PROBE_RSSI   = 8'h64;
   localparam logic [1:0] TGM_RSSI_ANALOG  = 2'h3;
   localparam logic [7:0] TGM_PF_DEFAULT   = 8'h00;
   localparam logic [7:0] TGM_PF_SLICER    = 8'h21;
   localparam logic [7:0] TGM_PF_LIMITER   = 8'h40;
   localparam logic [7:0] TGM_PF_LIM_BOTH  = 8'h41;
   localparam logic [7:0] TGM_PF_TX_DATA   = 8'h50;
   localparam logic [7:0] TGM_PF_RAMP_DONE = 8'h53;
   localparam logic [7:0] TGM_PF_SPORT_LO  = 8'ha0;
   localparam logic [7:0] TGM_PF_SPORT_HI  = 8'ha8;
   localparam logic [7:0] TGM_PF_TEST_DAC  = 8'hc9;

   localparam int TGM_NPINS = 6;

   typedef enum logic [2:0] {
      TGM_RT_DEFAULT   = 3'b000,
      TGM_RT_SLICER    = 3'b001,
      TGM_RT_LIMITER   = 3'b010,
      TGM_RT_LIM_BOTH  = 3'b011,
      TGM_RT_TX_DATA   = 3'b100,
      TGM_RT_RAMP_DONE = 3'b101,
      TGM_RT_SPORT     = 3'b110,
      TGM_RT_TEST_DAC  = 3'b111
   } tgm_route_e;

endpackage

// *** tgm_pin_route.sv ***
// next pin values for the selected pin function
`timescale 1ns/1ps
module tgm_pin_route
   import tgm_pkg::*;
(
   input  wire logic [7:0]           pin_function,
   input  wire logic                 slicer_out,
   input  wire logic                 lim_q_filt,
   input  wire logic                 lim_i_filt,
   input  wire logic                 lim_q_raw,
   input  wire logic                 lim_i_raw,
   input  wire logic                 tx_pkt_data,
   input  wire logic                 pa_ramp_done,
   input  wire logic                 test_conv_out,
   input  wire logic [TGM_NPINS-1:0] dflt_pin_out,
   input  wire logic [TGM_NPINS-1:0] dflt_pin_oe_n,
   input  wire logic [TGM_NPINS-1:0] sport_pin_out,
   input  wire logic [TGM_NPINS-1:0] sport_pin_oe_n,
   output logic      [TGM_NPINS-1:0] pin_out_nxt,
   output logic      [TGM_NPINS-1:0] pin_oe_n_nxt,
   output logic                      sport_en_nxt,
   output logic      [3:0]           sport_mode_nxt
);

   tgm_route_e                 route;
   logic       [TGM_NPINS-1:0] base_out;
   logic       [TGM_NPINS-1:0] base_oe_n;

   // ----------------------------------------------------------------
   // decode of the selector
   // ----------------------------------------------------------------
   always_comb begin
      sport_mode_nxt = 4'h0;
      if (pin_function == TGM_PF_SLICER) begin
         route = TGM_RT_SLICER;
      end else if (pin_function == TGM_PF_LIMITER) begin
         route = TGM_RT_LIMITER;
      end else if (pin_function == TGM_PF_LIM_BOTH) begin
         route = TGM_RT_LIM_BOTH;
      end else if (pin_function == TGM_PF_TX_DATA) begin
         route = TGM_RT_TX_DATA;
      end else if (pin_function == TGM_PF_RAMP_DONE) begin
         route = TGM_RT_RAMP_DONE;
      end else if (pin_function == TGM_PF_TEST_DAC) begin
         route = TGM_RT_TEST_DAC;
      end else if (pin_function >= TGM_PF_SPORT_LO &&
                   pin_function <= TGM_PF_SPORT_HI) begin
         route = TGM_RT_SPORT;
         sport_mode_nxt = 4'(pin_function - TGM_PF_SPORT_LO);
      end else begin
         route = TGM_RT_DEFAULT;
      end
      sport_en_nxt = (route == TGM_RT_SPORT);
   end

   // ----------------------------------------------------------------
   // per pin base function: default or serial port
   // ----------------------------------------------------------------
   for (genvar i = 0; i < TGM_NPINS; i++) begin : g_base
      assign base_out[i]  = (route == TGM_RT_SPORT) ? sport_pin_out[i]
                                                    : dflt_pin_out[i];
      assign base_oe_n[i] = (route == TGM_RT_SPORT) ? sport_pin_oe_n[i]
                                                    : dflt_pin_oe_n[i];
   end

   // ----------------------------------------------------------------
   // observation overrides
   // ----------------------------------------------------------------
   always_comb begin
      pin_out_nxt  = base_out;
      pin_oe_n_nxt = base_oe_n;
      unique case (route)
         TGM_RT_SLICER: begin
            pin_out_nxt[5]  = slicer_out;
            pin_oe_n_nxt[5] = 1'b0;
         end
         TGM_RT_LIMITER: begin
            pin_out_nxt[1:0]  = {lim_i_filt, lim_q_filt};
            pin_oe_n_nxt[1:0] = 2'h0;
         end
         TGM_RT_LIM_BOTH: begin
            pin_out_nxt[3:0]  = {lim_i_raw, lim_q_raw,
                                 lim_i_filt, lim_q_filt};
            pin_oe_n_nxt[3:0] = 4'h0;
         end
         TGM_RT_TX_DATA: begin
            pin_out_nxt[0]  = tx_pkt_data;
            pin_oe_n_nxt[0] = 1'b0;
         end
         TGM_RT_RAMP_DONE: begin
            pin_out_nxt[0]  = pa_ramp_done;
            pin_oe_n_nxt[0] = 1'b0;
         end
         TGM_RT_TEST_DAC: begin
            pin_out_nxt[0]  = test_conv_out;
            pin_oe_n_nxt[0] = 1'b0;
         end
         TGM_RT_SPORT, TGM_RT_DEFAULT: begin
            pin_out_nxt  = base_out;
            pin_oe_n_nxt = base_oe_n;
         end
      endcase
   end

endmodule

// *** tgm_mux_top.sv ***
// register file and registered pin outputs of the test signal mux
`timescale 1ns/1ps
module tgm_mux_top
   import tgm_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic [9:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata,
   input  wire logic                 slicer_out,
   input  wire logic                 lim_q_filt,
   input  wire logic                 lim_i_filt,
   input  wire logic                 lim_q_raw,
   input  wire logic                 lim_i_raw,
   input  wire logic                 tx_pkt_data,
   input  wire logic                 pa_ramp_done,
   input  wire logic                 test_conv_out,
   input  wire logic [TGM_NPINS-1:0] dflt_pin_out,
   input  wire logic [TGM_NPINS-1:0] dflt_pin_oe_n,
   input  wire logic [TGM_NPINS-1:0] sport_pin_out,
   input  wire logic [TGM_NPINS-1:0] sport_pin_oe_n,
   output logic      [TGM_NPINS-1:0] general_pin_out,
   output logic      [TGM_NPINS-1:0] general_pin_oe_n,
   output logic                      analog_test_pin_three_en,
   output logic      [3:0]           test_conv_scale,
   output logic                      sport_en,
   output logic      [3:0]           sport_mode
);

   typedef struct packed {
      logic [7:0]           probe;
      logic [7:0]           rssi;
      logic [7:0]           pinfn;
      logic [7:0]           scale;
      logic [7:0]           rdata;
      logic [TGM_NPINS-1:0] pin_out;
      logic [TGM_NPINS-1:0] pin_oe_n;
      logic                 probe_en;
      logic                 sport_en;
      logic [3:0]           sport_mode;
   } tgm_state_s;

   tgm_state_s                 st_r;
   tgm_state_s                 st_nxt;
   logic       [TGM_NPINS-1:0] pin_out_nxt;
   logic       [TGM_NPINS-1:0] pin_oe_n_nxt;
   logic                       sport_en_nxt;
   logic       [3:0]           sport_mode_nxt;

   // ----------------------------------------------------------------
   // pin routing
   // ----------------------------------------------------------------
   tgm_pin_route u_route (
      .pin_function   (st_r.pinfn),
      .slicer_out     (slicer_out),
      .lim_q_filt     (lim_q_filt),
      .lim_i_filt     (lim_i_filt),
      .lim_q_raw      (lim_q_raw),
      .lim_i_raw      (lim_i_raw),
      .tx_pkt_data    (tx_pkt_data),
      .pa_ramp_done   (pa_ramp_done),
      .test_conv_out  (test_conv_out),
      .dflt_pin_out   (dflt_pin_out),
      .dflt_pin_oe_n  (dflt_pin_oe_n),
      .sport_pin_out  (sport_pin_out),
      .sport_pin_oe_n (sport_pin_oe_n),
      .pin_out_nxt    (pin_out_nxt),
      .pin_oe_n_nxt   (pin_oe_n_nxt),
      .sport_en_nxt   (sport_en_nxt),
      .sport_mode_nxt (sport_mode_nxt)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      if (reg_wr) begin
         unique case (reg_addr)
            TGM_OFF_PROBE: st_nxt.probe = reg_wdata;
            TGM_OFF_RSSI:  st_nxt.rssi  = reg_wdata;
            TGM_OFF_PINFN: st_nxt.pinfn = reg_wdata;
            TGM_OFF_SCALE: st_nxt.scale = reg_wdata;
            default:       st_nxt.probe = st_r.probe;
         endcase
      end
      st_nxt.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            TGM_OFF_PROBE: st_nxt.rdata = st_r.probe;
            TGM_OFF_RSSI:  st_nxt.rdata = st_r.rssi;
            TGM_OFF_PINFN: st_nxt.rdata = st_r.pinfn;
            TGM_OFF_SCALE: st_nxt.rdata = st_r.scale;
            default:       st_nxt.rdata = 8'h00;
         endcase
      end
      st_nxt.pin_out    = pin_out_nxt;
      st_nxt.pin_oe_n   = pin_oe_n_nxt;
      st_nxt.sport_en   = sport_en_nxt;
      st_nxt.sport_mode = sport_mode_nxt;
      st_nxt.probe_en   = (st_r.probe == TGM_PROBE_RSSI) &&
                          (st_r.rssi[TGM_RSSI_SEL_LSB +: TGM_RSSI_SEL_W]
                           == TGM_RSSI_ANALOG);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r.probe      <= TGM_RST_PROBE;
         st_r.rssi       <= TGM_RST_RSSI;
         st_r.pinfn      <= TGM_RST_PINFN;
         st_r.scale      <= TGM_RST_SCALE;
         st_r.rdata      <= 8'h00;
         st_r.pin_out    <= '0;
         st_r.pin_oe_n   <= '1;
         st_r.probe_en   <= 1'b0;
         st_r.sport_en   <= 1'b0;
         st_r.sport_mode <= 4'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata                = st_r.rdata;
   assign general_pin_out          = st_r.pin_out;
   assign general_pin_oe_n         = st_r.pin_oe_n;
   assign analog_test_pin_three_en = st_r.probe_en;
   assign test_conv_scale          = st_r.scale[TGM_SCALE_LSB +: TGM_SCALE_W];
   assign sport_en                 = st_r.sport_en;
   assign sport_mode               = st_r.sport_mode;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_write(logic [9:0] a, logic [7:0] d);
      reg_wr && reg_addr == a && reg_wdata == d;
   endsequence

   sequence s_read(logic [9:0] a);
      reg_rd && reg_addr == a;
   endsequence

   AST_PROBE_ON: assert property (
      s_write(TGM_OFF_PROBE, TGM_PROBE_RSSI) ##1
      s_write(TGM_OFF_RSSI, 8'h03) ##1
      (!reg_wr) |=> analog_test_pin_three_en)
      else $error("analog probe not enabled");

   AST_PROBE_OFF: assert property (
      (st_r.probe != TGM_PROBE_RSSI) |=> !analog_test_pin_three_en)
      else $error("analog probe enabled without probe code");

   AST_SLICER: assert property (
      (st_r.pinfn == TGM_PF_SLICER) |=>
      general_pin_out[5] == $past(slicer_out) && !general_pin_oe_n[5])
      else $error("slicer not on pin five");

   AST_LIMITER: assert property (
      (st_r.pinfn == TGM_PF_LIMITER) |=>
      general_pin_out[1:0] == $past({lim_i_filt, lim_q_filt}) &&
      general_pin_oe_n[1:0] == 2'h0)
      else $error("limiter outputs misrouted");

   AST_LIM_BOTH: assert property (
      (st_r.pinfn == TGM_PF_LIM_BOTH) |=>
      general_pin_out[3:0] ==
      $past({lim_i_raw, lim_q_raw, lim_i_filt, lim_q_filt}) &&
      general_pin_oe_n[3:0] == 4'h0)
      else $error("filtered and raw limiter outputs misrouted");

   AST_TX_DATA: assert property (
      (st_r.pinfn == TGM_PF_TX_DATA) |=>
      general_pin_out[0] == $past(tx_pkt_data) && !general_pin_oe_n[0])
      else $error("transmit data not on pin zero");

   AST_RAMP: assert property (
      (st_r.pinfn == TGM_PF_RAMP_DONE) |=>
      general_pin_out[0] == $past(pa_ramp_done) && !general_pin_oe_n[0])
      else $error("ramp flag not on pin zero");

   AST_TEST_DAC: assert property (
      s_write(TGM_OFF_PINFN, TGM_PF_TEST_DAC) ##1 (!reg_wr) |=>
      general_pin_out[0] == $past(test_conv_out) && !general_pin_oe_n[0])
      else $error("test converter not on pin zero");

   AST_SCALE_READ: assert property (
      s_write(TGM_OFF_SCALE, reg_wdata) ##1 s_read(TGM_OFF_SCALE) |=>
      reg_rdata == $past(reg_wdata, 2) &&
      test_conv_scale == $past(reg_wdata[3:0], 2))
      else $error("gain field readback wrong");

   AST_SPORT: assert property (
      (st_r.pinfn >= TGM_PF_SPORT_LO && st_r.pinfn <= TGM_PF_SPORT_HI) |=>
      sport_en && sport_mode == $past(st_r.pinfn[3:0]) &&
      general_pin_out == $past(sport_pin_out))
      else $error("serial mode not selected");

   AST_DEFAULT: assert property (
      (st_r.pinfn == TGM_PF_DEFAULT || st_r.pinfn == 8'hff) |=>
      !sport_en && general_pin_out == $past(dflt_pin_out) &&
      general_pin_oe_n == $past(dflt_pin_oe_n))
      else $error("default pin function lost");

   AST_RDATA_ONE: assert property (
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");

endmodule

// *** tgm_src_model.sv ***
// source and default pin pattern model for the test signal mux
`timescale 1ns/1ps
module tgm_src_model
   import tgm_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   output logic                      slicer_out,
   output logic                      lim_q_filt,
   output logic                      lim_i_filt,
   output logic                      lim_q_raw,
   output logic                      lim_i_raw,
   output logic                      tx_pkt_data,
   output logic                      pa_ramp_done,
   output logic                      test_conv_out,
   output logic      [TGM_NPINS-1:0] dflt_pin_out,
   output logic      [TGM_NPINS-1:0] dflt_pin_oe_n,
   output logic      [TGM_NPINS-1:0] sport_pin_out,
   output logic      [TGM_NPINS-1:0] sport_pin_oe_n
);
   // ----------------------------------------------------------------
   // pattern that changes every cycle, so stale values rarely match
   // ----------------------------------------------------------------
   logic [15:0] pat_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         pat_r <= 16'h0001;
      end else begin
         pat_r <= {pat_r[14:0], pat_r[15] ^ pat_r[13] ^ pat_r[12] ^ pat_r[10]};
      end
   end

   assign {slicer_out, lim_q_filt, lim_i_filt, lim_q_raw} = pat_r[7:4];
   assign {lim_i_raw, tx_pkt_data, pa_ramp_done, test_conv_out} = pat_r[3:0];
   assign dflt_pin_out   = pat_r[13:8];
   assign dflt_pin_oe_n  = pat_r[15:10] ^ pat_r[5:0];
   assign sport_pin_out  = ~pat_r[5:0];
   assign sport_pin_oe_n = pat_r[11:6];
endmodule

// *** test_and_gpio_signal_mux_tb.sv ***
// self-checking testbench of the test signal mux
`timescale 1ns/1ps
module test_and_gpio_signal_mux_tb;
   import tgm_pkg::*;
   logic                 clk = 1'b0;
   logic                 reset = 1'b1;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [9:0]           reg_addr = 10'h000;
   logic [7:0]           reg_wdata = 8'h00;
   logic [7:0]           reg_rdata;
   logic [7:0]           rv;
   logic                 slicer_out, lim_q_filt, lim_i_filt, lim_q_raw;
   logic                 lim_i_raw, tx_pkt_data, pa_ramp_done, test_conv_out;
   logic [TGM_NPINS-1:0] dflt_pin_out, dflt_pin_oe_n;
   logic [TGM_NPINS-1:0] sport_pin_out, sport_pin_oe_n;
   logic [TGM_NPINS-1:0] general_pin_out, general_pin_oe_n;
   logic                 atb_en, sport_en;
   logic [3:0]           scale, sport_mode;
   int                   mismatches = 0;
   int                   tests_run = 0;
   logic [7:0] codes [20] = '{8'h00, 8'h21, 8'h40, 8'h41, 8'h50, 8'h53,
      8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8,
      8'hc9, 8'h22, 8'hff, 8'h9f, 8'ha9};
   logic [7:0] probes [5] = '{8'h64, 8'h64, 8'h65, 8'h64, 8'he4};
   logic [7:0] rssis  [5] = '{8'h03, 8'h02, 8'h03, 8'hff, 8'h03};
   logic       atbs   [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};

   initial begin
      forever #4 clk = ~clk;
   end

   tgm_src_model src (
      .clk(clk), .reset(reset), .slicer_out(slicer_out),
      .lim_q_filt(lim_q_filt), .lim_i_filt(lim_i_filt),
      .lim_q_raw(lim_q_raw), .lim_i_raw(lim_i_raw),
      .tx_pkt_data(tx_pkt_data), .pa_ramp_done(pa_ramp_done),
      .test_conv_out(test_conv_out), .dflt_pin_out(dflt_pin_out),
      .dflt_pin_oe_n(dflt_pin_oe_n), .sport_pin_out(sport_pin_out),
      .sport_pin_oe_n(sport_pin_oe_n));

   tgm_mux_top dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .slicer_out(slicer_out), .lim_q_filt(lim_q_filt),
      .lim_i_filt(lim_i_filt), .lim_q_raw(lim_q_raw), .lim_i_raw(lim_i_raw),
      .tx_pkt_data(tx_pkt_data), .pa_ramp_done(pa_ramp_done),
      .test_conv_out(test_conv_out), .dflt_pin_out(dflt_pin_out),
      .dflt_pin_oe_n(dflt_pin_oe_n), .sport_pin_out(sport_pin_out),
      .sport_pin_oe_n(sport_pin_oe_n), .general_pin_out(general_pin_out),
      .general_pin_oe_n(general_pin_oe_n),
      .analog_test_pin_three_en(atb_en), .test_conv_scale(scale),
      .sport_en(sport_en), .sport_mode(sport_mode));

   // ----------------------------------------------------------------
   // bus tasks and compare
   // ----------------------------------------------------------------
   task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(logic [9:0] a, logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // two writes back to back, strobe held high between them
   task automatic wr2(logic [9:0] a0, logic [7:0] d0,
                      logic [9:0] a1, logic [7:0] d1);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a0;
      reg_wdata <= d0;
      @(posedge clk);
      reg_addr  <= a1;
      reg_wdata <= d1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // write followed at once by a read of the same address
   task automatic wr_rd(logic [9:0] a, logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask

   task automatic rd(logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // expected pins from selector, sources and default/serial values
   // ----------------------------------------------------------------
   function automatic logic [11:0] exp_pins(logic [7:0] s, logic [7:0] sr,
                                            logic [23:0] v);
      logic [5:0] o;
      logic [5:0] e;
      o = v[5:0];
      e = v[11:6];
      if (s >= TGM_PF_SPORT_LO && s <= TGM_PF_SPORT_HI) begin
         o = v[17:12];
         e = v[23:18];
      end
      case (s)
         TGM_PF_SLICER: begin
            o[5] = sr[7];
            e[5] = 1'b0;
         end
         TGM_PF_LIMITER: begin
            o[1:0] = {sr[5], sr[6]};
            e[1:0] = 2'h0;
         end
         TGM_PF_LIM_BOTH: begin
            o[3:0] = {sr[3], sr[4], sr[5], sr[6]};
            e[3:0] = 4'h0;
         end
         TGM_PF_TX_DATA: begin
            o[0] = sr[2];
            e[0] = 1'b0;
         end
         TGM_PF_RAMP_DONE: begin
            o[0] = sr[1];
            e[0] = 1'b0;
         end
         TGM_PF_TEST_DAC: begin
            o[0] = sr[0];
            e[0] = 1'b0;
         end
         default: ;
      endcase
      return {e, o};
   endfunction

   task automatic pin_chk(logic [7:0] s);
      logic [7:0]  sr;
      logic [23:0] v;
      logic        sp;
      @(negedge clk);
      sr = {slicer_out, lim_q_filt, lim_i_filt, lim_q_raw,
            lim_i_raw, tx_pkt_data, pa_ramp_done, test_conv_out};
      v  = {sport_pin_oe_n, sport_pin_out, dflt_pin_oe_n, dflt_pin_out};
      sp = (s >= TGM_PF_SPORT_LO && s <= TGM_PF_SPORT_HI);
      @(negedge clk);
      chk("pins", exp_pins(s, sr, v),
          {general_pin_oe_n, general_pin_out});
      chk("sport", {7'h0, sp, sp ? s[3:0] : 4'h0},
          {7'h0, sport_en, sport_mode});
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 chk("reset pins", 12'hfc0, {general_pin_oe_n, general_pin_out});
      chk("reset misc", 12'h004, {6'h0, atb_en, sport_en, scale});
      rd(TGM_OFF_PROBE, rv);
      chk("probe reset", {4'h0, TGM_RST_PROBE}, {4'h0, rv});
      rd(TGM_OFF_RSSI, rv);
      chk("rssi reset", {4'h0, TGM_RST_RSSI}, {4'h0, rv});
      rd(TGM_OFF_PINFN, rv);
      chk("pinfn reset", {4'h0, TGM_RST_PINFN}, {4'h0, rv});
      rd(TGM_OFF_SCALE, rv);
      chk("scale reset", {4'h0, TGM_RST_SCALE}, {4'h0, rv});
      wr(10'h3fc, 8'h5a);
      rd(10'h3fc, rv);
      chk("unmapped", 12'h000, {4'h0, rv});
      wr_rd(TGM_OFF_SCALE, 8'h00, rv);
      chk("scale zero", 12'h000, {rv, scale});
      wr_rd(TGM_OFF_SCALE, 8'hf5, rv);
      chk("scale f5", 12'hf55, {rv, scale});
      for (int i = 0; i < 5; i++) begin
         wr2(TGM_OFF_PROBE, probes[i], TGM_OFF_RSSI, rssis[i]);
         repeat (2) @(posedge clk);
         #1 chk("probe pin", {11'h0, atbs[i]}, {11'h0, atb_en});
      end
      wr(TGM_OFF_SCALE, 8'h00);
      foreach (codes[i]) begin
         wr(TGM_OFF_PINFN, codes[i]);
         repeat (2) @(posedge clk);
         for (int k = 0; k < 4; k++) begin
            pin_chk(codes[i]);
         end
      end
      wr(TGM_OFF_PINFN, TGM_PF_TX_DATA);
      rd(TGM_OFF_PINFN, rv);
      chk("pinfn read", {4'h0, TGM_PF_TX_DATA}, {4'h0, rv});
      @(posedge clk);
      #1 chk("rdata idle", 12'h000, {4'h0, reg_rdata});
      give_verdict();
   end
endmodule
